// ### src/i2c_regs_pkg.sv
// register map, field layout and reset values of the i2c address and interrupt-enable block
package i2c_regs_pkg;
    localparam logic [5:0] OFS_ADDR_MASK = 6'h00;
    localparam logic [5:0] OFS_TARGET_ADDR = 6'h04;
    localparam logic [5:0] OFS_IRQ_ENABLE = 6'h08;
    localparam logic [5:0] OFS_OWN_ADDR0 = 6'h0C;
    localparam logic [5:0] OFS_CONTROL = 6'h1C;
    localparam logic [5:0] OFS_STATUS = 6'h20;

    localparam int ADDR_W = 10;
    localparam int IRQ_W = 15;
    localparam int OWN_CNT = 4;

    localparam logic [9:0] MASK_RESET = 10'h3FF;
    localparam logic [9:0] TARGET_RESET = 10'h000;
    localparam logic [14:0] IE_RESET = 15'h0000;
    localparam logic [9:0] SEVEN_BIT_SPAN = 10'h07F;
    localparam logic [9:0] TEN_BIT_SPAN = 10'h3FF;

    // own-address register layout
    localparam int OWN_EN_BIT = 10;

    // control register layout
    localparam int CTL_HOLD_BIT = 0;
    localparam int CTL_CONTROLLER_BIT = 1;
    localparam int CTL_TEN_OWN_BIT = 2;
    localparam int CTL_TEN_TARGET_BIT = 3;
    localparam logic [3:0] CTL_RESET = 4'h1;

    // interrupt-enable and status field positions
    localparam int RX_EN_0 = 0;
    localparam int TX_EN_0 = 1;
    localparam int START_EN = 2;
    localparam int STOP_EN = 3;
    localparam int ARB_LOST_EN = 4;
    localparam int NACK_EN = 5;
    localparam int BYTE_COUNT_EN = 6;
    localparam int CLK_LOW_EN = 7;
    localparam int RX_EN_1 = 8;
    localparam int BIT9_EN = 14;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : i2c_regs_pkg

// ### src/addr_cmp_if.sv
// carrier between the top and one own-address comparator
`timescale 1ns/1ps
interface addr_cmp_if;
    logic [9:0] ownAddr;
    logic [9:0] compareMask;
    logic [9:0] rxAddr;
    logic tenBit;
    logic enable;
    logic match;
    modport owner (output ownAddr, compareMask, rxAddr, tenBit, enable, input match);
    modport cmp (input ownAddr, compareMask, rxAddr, tenBit, enable, output match);
endinterface : addr_cmp_if

// ### src/addr_match.sv
// masked compare of a received bus address against one own address
`timescale 1ns/1ps
module addr_match
    import i2c_regs_pkg::*;
(
    // comparator side
    addr_cmp_if.cmp port
);
    wire [9:0] span;
    wire [9:0] diff;

    // cleared mask bits and bits above the address width are don't-care
    assign span = port.tenBit ? TEN_BIT_SPAN : SEVEN_BIT_SPAN; // [R14]
    assign diff = (port.ownAddr ^ port.rxAddr) & port.compareMask & span; // [R1] [R2]
    assign port.match = port.enable && (diff == 10'h000);
endmodule : addr_match

// ### src/i2c_addr_mask_target_irq_enable.sv
// register block: own-address mask, target address, interrupt enables, over axi4-lite
//
// Behaviour
// R1: a cleared mask bit makes that address bit a don't-care in the own-address compare.
// R2: the mask resets to all ones, which gives an exact compare.
// R3: software changes the mask only while the soft reset hold bit is one.
// R4: the target address is used only in controller operation and ignored as target.
// R5: the target address is right justified, bit 6 is the top bit in seven-bit mode and bits 9-7 are ignored.
// R6: in ten-bit mode bit 9 of the target address is the top bit sent on the bus.
// R7: enable bit 14 gates the ninth-bit interrupt and resets to zero.
// R8: transmit and receive enables per own address sit at bits 1/0 and 8 to 13, each resetting to zero.
// R9: enable bit 7 gates the clock-low timeout interrupt and resets to zero.
// R10: enable bit 6 gates the byte counter interrupt and resets to zero.
// R11: enable bit 5 gates not-acknowledge and bit 4 gates arbitration lost.
// R12: enable bit 3 gates the stop-condition interrupt and resets to zero.
// R13: enable bit 2 gates the start-condition interrupt and resets to zero.
// R14: each own-address field is right justified, top bit 6 in seven-bit mode and 9 in ten-bit mode.
// R15: transmit flag 0 sets on an empty transmit buffer as controller, or as target once own address 0 matched.
// R16: a source requests an interrupt only while its pending flag and its enable are both one.
// R17: reserved bits of mask, target-address and enable registers read zero and ignore writes.
`timescale 1ns/1ps
module i2c_addr_mask_target_irq_enable
    import i2c_regs_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // axi4-lite write channels
    input wire logic [5:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read channels
    input wire logic [5:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // protocol engine events, one-cycle pulses in the status layout
    input wire logic [14:0] eventIn,
    input wire logic txBufEmpty,
    input wire logic [9:0] rxAddr,
    input wire logic rxAddrValid,
    input wire logic frameStop,
    // toward the protocol engine
    output logic [9:0] busTargetAddr,
    output logic [3:0] ownAddrHit,
    output logic [14:0] irqReq,
    output logic irq
);
    logic [9:0] addrMask;
    logic [9:0] targetAddr;
    logic [14:0] irqEnable;
    logic [10:0] ownAddr [OWN_CNT];
    logic [3:0] control;
    logic [14:0] status;
    logic [3:0] seenOwn;
    logic [5:0] wrAddr;
    logic [31:0] wrData;
    logic [3:0] wrStrb;
    logic haveAw;
    logic haveW;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;

    wire softResetHold = control[CTL_HOLD_BIT];
    wire controllerMode = control[CTL_CONTROLLER_BIT];
    wire tenBitOwn = control[CTL_TEN_OWN_BIT];
    wire tenBitTarget = control[CTL_TEN_TARGET_BIT];

    // write channel: address and data may arrive in either order
    assign s_axi_awready = !haveAw && !s_axi_bvalid;
    assign s_axi_wready = !haveW && !s_axi_bvalid;
    wire doWrite = haveAw && haveW && !s_axi_bvalid;
    wire [15:0] laneMask = {{8{wrStrb[1]}}, {8{wrStrb[0]}}};
    wire wrMask = doWrite && (wrAddr == OFS_ADDR_MASK);
    wire wrTarget = doWrite && (wrAddr == OFS_TARGET_ADDR);
    wire wrIe = doWrite && (wrAddr == OFS_IRQ_ENABLE);
    wire wrCtl = doWrite && (wrAddr == OFS_CONTROL);
    wire wrOwnRange = doWrite && (wrAddr >= OFS_OWN_ADDR0) && (wrAddr < OFS_CONTROL);
    wire [1:0] wrOwnIdx = 2'((wrAddr - OFS_OWN_ADDR0) >> 2);
    wire wrMapped = wrMask || wrTarget || wrIe || wrCtl || wrOwnRange || (doWrite && wrAddr == OFS_STATUS);

    // merge written bytes with the old value; reserved bits are cut off by the field width
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] data, input logic [15:0] lanes);
        merge = (old & ~lanes) | (data[15:0] & lanes);
    endfunction : merge

    wire [15:0] next_mask = merge({6'h00, addrMask}, wrData, laneMask);
    wire [15:0] next_target = merge({6'h00, targetAddr}, wrData, laneMask);
    wire [15:0] next_ie = merge({1'b0, irqEnable}, wrData, laneMask);
    wire [15:0] next_ctl = merge({12'h000, control}, wrData, laneMask);
    wire [15:0] next_own = merge({5'h00, ownAddr[wrOwnIdx]}, wrData, laneMask);

    // capture write address and data until both are present
    always_ff @(posedge clk) begin
        if (reset) begin
            haveAw <= 1'b0;
            haveW <= 1'b0;
            wrAddr <= 6'h00;
            wrData <= 32'h0000_0000;
            wrStrb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                haveAw <= 1'b1;
                wrAddr <= {s_axi_awaddr[5:2], 2'h0};
            end else if (doWrite) begin
                haveAw <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                haveW <= 1'b1;
                wrData <= s_axi_wdata;
                wrStrb <= s_axi_wstrb;
            end else if (doWrite) begin
                haveW <= 1'b0;
            end
        end
    end

    // write response one cycle after both halves are held
    always_ff @(posedge clk) begin
        if (reset) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrMapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // configuration registers; mask and own addresses only move while held in soft reset
    always_ff @(posedge clk) begin
        if (reset) begin
            addrMask <= MASK_RESET; // [R2]
            targetAddr <= TARGET_RESET;
            irqEnable <= IE_RESET; // [R7] [R8] [R9] [R10] [R12] [R13]
            control <= CTL_RESET;
            for (int i = 0; i < OWN_CNT; i++) begin
                ownAddr[i] <= 11'h000;
            end
        end else begin
            if (wrMask && softResetHold) begin
                addrMask <= next_mask[9:0]; // [R3] [R17]
            end
            if (wrTarget) begin
                targetAddr <= next_target[9:0]; // [R17]
            end
            if (wrIe) begin
                irqEnable <= next_ie[14:0]; // [R17]
            end
            if (wrCtl) begin
                control <= next_ctl[3:0];
            end
            if (wrOwnRange && softResetHold) begin
                ownAddr[wrOwnIdx] <= next_own[10:0];
            end
        end
    end

    // own-address comparators, one per own address
    wire [3:0] hitNow;
    generate
        for (genvar g = 0; g < OWN_CNT; g++) begin : gen_cmp
            addr_cmp_if link();
            assign link.ownAddr = ownAddr[g][9:0];
            assign link.compareMask = addrMask;
            assign link.rxAddr = rxAddr;
            assign link.tenBit = tenBitOwn;
            assign link.enable = (g == 0) || ownAddr[g][OWN_EN_BIT];
            assign hitNow[g] = link.match && rxAddrValid;
            addr_match u_cmp (
                .port(link.cmp)
            );
        end
    endgenerate

    // remember which own address was called in this frame; a stop or soft reset forgets it
    always_ff @(posedge clk) begin
        if (reset || frameStop || softResetHold) begin
            seenOwn <= 4'h0;
        end else begin
            seenOwn <= seenOwn | hitNow;
        end
    end

    // transmit requests: index 0 also serves controller operation
    wire [3:0] txCall;
    assign txCall[0] = txBufEmpty && (controllerMode || seenOwn[0]); // [R15]
    assign txCall[3:1] = {3{txBufEmpty && !controllerMode}} & seenOwn[3:1];
    wire [14:0] txSet = {1'b0, txCall[3], 1'b0, txCall[2], 1'b0, txCall[1], 7'h00, txCall[0], 1'b0};
    wire [14:0] setBits = eventIn | txSet;

    // read decode
    wire rdTake = s_axi_arvalid && s_axi_arready;
    wire [5:0] rdAddr = {s_axi_araddr[5:2], 2'h0};
    wire rdOwnRange = (rdAddr >= OFS_OWN_ADDR0) && (rdAddr < OFS_CONTROL);
    wire [1:0] rdOwnIdx = 2'((rdAddr - OFS_OWN_ADDR0) >> 2);
    wire rdStatus = rdTake && (rdAddr == OFS_STATUS);
    assign s_axi_arready = !s_axi_rvalid;

    // sticky status: a new event in the reading cycle survives the clear
    always_ff @(posedge clk) begin
        if (reset) begin
            status <= 15'h0000;
        end else begin
            status <= (rdStatus ? 15'h0000 : status) | setBits;
        end
    end

    // read data mux; unused upper bits read zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_rresp = RESP_OKAY;
        if (rdAddr == OFS_ADDR_MASK) begin
            next_rdata[9:0] = addrMask; // [R17]
        end else if (rdAddr == OFS_TARGET_ADDR) begin
            next_rdata[9:0] = targetAddr;
        end else if (rdAddr == OFS_IRQ_ENABLE) begin
            next_rdata[14:0] = irqEnable;
        end else if (rdOwnRange) begin
            next_rdata[10:0] = ownAddr[rdOwnIdx];
        end else if (rdAddr == OFS_CONTROL) begin
            next_rdata[3:0] = control;
        end else if (rdAddr == OFS_STATUS) begin
            next_rdata[14:0] = status;
        end else begin
            next_rresp = RESP_SLVERR;
        end
    end

    // read answer one cycle after the address is taken
    always_ff @(posedge clk) begin
        if (reset) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (rdTake) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // target address reaches the bus only as controller, trimmed to seven bits unless ten-bit
    always_ff @(posedge clk) begin
        if (reset || !controllerMode) begin
            busTargetAddr <= 10'h000; // [R4]
        end else if (tenBitTarget) begin
            busTargetAddr <= targetAddr; // [R6]
        end else begin
            busTargetAddr <= targetAddr & SEVEN_BIT_SPAN; // [R5]
        end
    end

    // per-source requests: bit 14 ninth bit, 13..8 and 1..0 own-address tx/rx, 7..2 bus events
    assign irqReq = status & irqEnable; // [R7] [R8] [R9] [R10] [R11] [R12] [R13] [R16]
    assign irq = |irqReq; // [R16]
    assign ownAddrHit = seenOwn;

    property p_mask_reset;
        @(posedge clk) $fell(reset) |-> addrMask == 10'h3FF;
    endproperty
    a_mask_reset: assert property (p_mask_reset) else $error("mask not all ones after reset"); // [R2]

    // full mask must behave as a plain compare over the active address width
    property p_exact_compare;
        @(posedge clk) disable iff (reset)
        (addrMask == 10'h3FF && rxAddrValid) |->
            hitNow[0] == (tenBitOwn ? (ownAddr[0][9:0] == rxAddr) : (ownAddr[0][6:0] == rxAddr[6:0]));
    endproperty
    a_exact_compare: assert property (p_exact_compare) else $error("full mask did not compare exactly"); // [R2]

    property p_mask_hold;
        @(posedge clk) disable iff (reset) !softResetHold |=> $stable(addrMask);
    endproperty
    a_mask_hold: assert property (p_mask_hold) else $error("mask moved outside soft reset hold"); // [R3]

    property p_target_ignored;
        @(posedge clk) disable iff (reset) !controllerMode |=> busTargetAddr == 10'h000;
    endproperty
    a_target_ignored: assert property (p_target_ignored) else $error("target address used as target"); // [R4]

    property p_seven_bit;
        @(posedge clk) disable iff (reset)
        (controllerMode && !tenBitTarget) |=> busTargetAddr == {3'h0, $past(targetAddr[6:0])};
    endproperty
    a_seven_bit: assert property (p_seven_bit) else $error("seven-bit target not right justified"); // [R5]

    property p_ten_bit;
        @(posedge clk) disable iff (reset) (controllerMode && tenBitTarget) |=> busTargetAddr == $past(targetAddr);
    endproperty
    a_ten_bit: assert property (p_ten_bit) else $error("ten-bit target address altered"); // [R6]

    property p_ninth_irq;
        @(posedge clk) disable iff (reset) (eventIn[14] && irqEnable[14] && !wrIe) |=> irq ##0 irqReq[14];
    endproperty
    a_ninth_irq: assert property (p_ninth_irq) else $error("enabled ninth-bit event gave no request"); // [R7]

    property p_gate;
        @(posedge clk) disable iff (reset) (status[4] && !irqEnable[4]) |-> !irqReq[4];
    endproperty
    a_gate: assert property (p_gate) else $error("disabled source requested"); // [R11]

    property p_tx0;
        @(posedge clk) disable iff (reset) (txBufEmpty && controllerMode) |=> status[TX_EN_0];
    endproperty
    a_tx0: assert property (p_tx0) else $error("transmit flag 0 not set as controller"); // [R15]

    property p_reserved;
        @(posedge clk) disable iff (reset)
        (rdTake && rdAddr == OFS_IRQ_ENABLE) |=> s_axi_rdata[31:15] == 17'h00000;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved enable bits read nonzero"); // [R17]
endmodule : i2c_addr_mask_target_irq_enable

// ### verif/engine_model.sv
// behavioural protocol engine feeding events and received addresses to the register block
`timescale 1ns/1ps
module engine_model (
    // clock
    input wire logic clk,
    // toward the register block
    output logic [14:0] eventIn,
    output logic txBufEmpty,
    output logic [9:0] rxAddr,
    output logic rxAddrValid,
    output logic frameStop
);
    // idle levels at time zero
    initial begin
        eventIn = 15'h0000;
        txBufEmpty = 1'b0;
        rxAddr = 10'h3FF;
        rxAddrValid = 1'b0;
        frameStop = 1'b0;
    end

    // one-cycle event pulse
    task automatic pulse(input logic [14:0] ev);
        @(posedge clk);
        eventIn <= ev;
        @(posedge clk);
        eventIn <= 15'h0000;
    endtask : pulse

    // address with strobe; stale bits inverted so nothing leans on a held value
    task automatic send_addr(input logic [9:0] a);
        @(posedge clk);
        rxAddr <= a;
        rxAddrValid <= 1'b1;
        @(posedge clk);
        rxAddrValid <= 1'b0;
        rxAddr <= ~a;
    endtask : send_addr

    // end of frame pulse
    task automatic end_frame();
        @(posedge clk);
        frameStop <= 1'b1;
        @(posedge clk);
        frameStop <= 1'b0;
    endtask : end_frame

    // buffer-empty level
    task automatic set_empty(input logic e);
        @(posedge clk);
        txBufEmpty <= e;
    endtask : set_empty
endmodule : engine_model

// ### verif/tb_i2c_addr_mask_target_irq_enable.sv
// self-checking bench for the address mask, target address and interrupt-enable block
`timescale 1ns/1ps
module tb_i2c_addr_mask_target_irq_enable
    import i2c_regs_pkg::*;
;
    typedef struct packed {
        logic [14:0] ie;
        logic [14:0] ev;
        logic [14:0] req;
    } irq_row_t;
    localparam logic [31:0] CTRL = 32'h1 << CTL_CONTROLLER_BIT;
    localparam logic [31:0] TEN_T = 32'h1 << CTL_TEN_TARGET_BIT;
    logic clk, reset;
    logic [5:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, data;
    logic [3:0] s_axi_wstrb, ownAddrHit;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [14:0] eventIn, irqReq;
    logic [9:0] rxAddr, busTargetAddr;
    logic txBufEmpty, rxAddrValid, frameStop, irq;
    int errors;
    int check_count;

    // ordinary cases, run in controller mode so every engine event may flag
    irq_row_t rows [9] = '{
        '{15'h7FFF, 15'h0004, 15'h0004},
        '{15'h7FFB, 15'h0004, 15'h0000},
        '{15'h0008, 15'h0008, 15'h0008},
        '{15'h0030, 15'h0030, 15'h0030},
        '{15'h0010, 15'h0030, 15'h0010},
        '{15'h0040, 15'h00C0, 15'h0040},
        '{15'h0080, 15'h00C0, 15'h0080},
        '{15'h4000, 15'h40FC, 15'h4000},
        '{15'h3F03, 15'h7FFF, 15'h3F03}
    };

    i2c_addr_mask_target_irq_enable i2c_addr_mask_target_irq_enable_i (.*);
    engine_model engine_model_i (.*);

    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // compares, one per kind of result
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_resp

    // axi4-lite write: address and data offered together, each dropped once taken
    task automatic axi_write(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n == 40) errors++;
    endtask : axi_write

    // axi4-lite read, data taken at the edge that sees rvalid
    task automatic axi_read(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n == 40) errors++;
    endtask : axi_read

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        axi_write(a, d, resp);
        chk_resp("write resp", RESP_OKAY, resp);
    endtask : wr

    task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp, input string what);
        axi_read(a, data, resp);
        chk_resp(what, RESP_OKAY, resp);
        chk(what, exp, data);
    endtask : rd_chk

    // fresh frame, one address, then the remembered hits
    task automatic hit(input logic [9:0] a, input logic [3:0] exp);
        engine_model_i.end_frame();
        engine_model_i.send_addr(a);
        #1;
        chk("ownAddrHit", {28'h0, exp}, {28'h0, ownAddrHit});
    endtask : hit

    // engine copy lags the register by a cycle, so let it settle
    task automatic tgt(input logic [31:0] ctl, input logic [9:0] exp);
        wr(OFS_CONTROL, ctl);
        repeat (2) @(posedge clk);
        #1;
        chk("busTargetAddr", {22'h0, exp}, {22'h0, busTargetAddr});
    endtask : tgt

    task automatic end_sim();
        if (errors == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim

    // watchdog far beyond the few hundred cycles the run needs
    initial begin
        #60000;
        errors++;
        end_sim();
    end

    // reset, ordinary rows, then awkward cases by hand
    initial begin
        errors = 0;
        check_count = 0;
        reset = 1'b1;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        rd_chk(OFS_ADDR_MASK, {22'h0, MASK_RESET}, "mask");
        rd_chk(OFS_TARGET_ADDR, 32'h0, "target");
        rd_chk(OFS_IRQ_ENABLE, 32'h0, "enable");
        wr(OFS_CONTROL, CTRL);
        foreach (rows[i]) begin
            wr(OFS_IRQ_ENABLE, {17'h1FFFF, rows[i].ie});
            rd_chk(OFS_IRQ_ENABLE, {17'h0, rows[i].ie}, "enable");
            engine_model_i.pulse(rows[i].ev);
            #1;
            chk("irqReq", {17'h0, rows[i].req}, {17'h0, irqReq});
            chk("irq", {31'h0, |rows[i].req}, {31'h0, irq});
            rd_chk(OFS_STATUS, {17'h0, rows[i].ev}, "status");
            #1;
            chk("irq", 32'h0, {31'h0, irq});
        end
        // mask: exact at reset, widened only while held
        wr(OFS_CONTROL, 32'h1);
        wr(OFS_OWN_ADDR0, 32'h055);
        wr(OFS_CONTROL, 32'h0);
        wr(OFS_ADDR_MASK, 32'h3FE);
        rd_chk(OFS_ADDR_MASK, {22'h0, MASK_RESET}, "mask");
        hit(10'h055, 4'h1);
        hit(10'h054, 4'h0);
        wr(OFS_CONTROL, 32'h1);
        wr(OFS_ADDR_MASK, 32'hFFFF_FFFE);
        wr(OFS_CONTROL, 32'h0);
        rd_chk(OFS_ADDR_MASK, 32'h3FE, "mask");
        hit(10'h054, 4'h1);
        hit(10'h056, 4'h0);
        // transmit flag 0 as target waits for own address 0
        wr(OFS_IRQ_ENABLE, 32'h2);
        engine_model_i.set_empty(1'b1);
        repeat (2) @(posedge clk);
        #1;
        chk("irqReq", 32'h0, {17'h0, irqReq});
        engine_model_i.send_addr(10'h054);
        repeat (2) @(posedge clk);
        #1;
        chk("irqReq", 32'h2, {17'h0, irqReq});
        // ten-bit own address: bit 9 takes part in the compare
        wr(OFS_CONTROL, 32'h5);
        wr(OFS_OWN_ADDR0, 32'h255);
        wr(OFS_CONTROL, 32'h4);
        hit(10'h254, 4'h1);
        hit(10'h054, 4'h0);
        // target address reaches the engine only as controller
        wr(OFS_TARGET_ADDR, 32'hFFFF_FFFF);
        rd_chk(OFS_TARGET_ADDR, 32'h3FF, "target");
        tgt(32'h0, 10'h000);
        tgt(CTRL, 10'h07F);
        tgt(CTRL | TEN_T, 10'h3FF);
        // unmapped place
        axi_write(6'h3C, 32'hFFFF_FFFF, resp);
        chk_resp("write resp", RESP_SLVERR, resp);
        axi_read(6'h3C, data, resp);
        chk_resp("read resp", RESP_SLVERR, resp);
        chk("read data", 32'h0, data);
        // second reset in mid-run
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        #1;
        chk("irq", 32'h0, {31'h0, irq});
        chk("busTargetAddr", 32'h0, {22'h0, busTargetAddr});
        rd_chk(OFS_ADDR_MASK, {22'h0, MASK_RESET}, "mask");
        rd_chk(OFS_IRQ_ENABLE, {17'h0, IE_RESET}, "enable");
        end_sim();
    end
endmodule : tb_i2c_addr_mask_target_irq_enable
